// ==== pkg/spt_params.svh ====
`ifndef SPT_PARAMS_SVH
`define SPT_PARAMS_SVH

// ==========================================================================
// Register byte offsets.
`define SPT_OFF_BUFFER 8'h00
`define SPT_OFF_CTRL1 8'h04
`define SPT_OFF_STATUS 8'h08
`define SPT_OFF_ADDR 8'h0C
`define SPT_OFF_CTRL2 8'h10

// ==========================================================================
// Reset values.
`define SPT_CTRL1_RESET 8'h00
`define SPT_STATUS_RESET 2'h0
`define SPT_ADDR_RESET 8'h00
`define SPT_CTRL2_RESET 8'h00

// ==========================================================================
// Field positions of serial_control_one and serial_status.
`define SPT_C1_WCOL 7
`define SPT_C1_OVF 6
`define SPT_C1_EN 5
`define SPT_C1_CKP 4
`define SPT_ST_SMP 7
`define SPT_ST_CKE 6

// ==========================================================================
// Half periods of the master serial clock in system clocks, and bit count.
`define SPT_HALF_DIV4 8'h02
`define SPT_HALF_DIV16 8'h08
`define SPT_HALF_DIV64 8'h20
`define SPT_LAST_BIT 3'h7
`define SPT_LAST_EDGE 4'hF
`define SPT_RESP_OKAY 2'h0
`define SPT_RESP_SLVERR 2'h2

`endif

// ==== pkg/spt_pkg.sv ====
package spt_pkg;

    // ======================================================================
    // Operating modes held in port_mode_field.
    typedef enum logic [3:0]
    {
        SPT_MODE_MDIV4 = 4'b0000,
        SPT_MODE_MDIV16 = 4'b0001,
        SPT_MODE_MDIV64 = 4'b0010,
        SPT_MODE_MTIMER = 4'b0011,
        SPT_MODE_SSEL = 4'b0100,
        SPT_MODE_SFREE = 4'b0101,
        SPT_MODE_I2C_S7 = 4'b0110,
        SPT_MODE_I2C_S10 = 4'b0111,
        SPT_MODE_I2C_M = 4'b1000,
        SPT_MODE_I2C_FW = 4'b1011,
        SPT_MODE_I2C_S7SP = 4'b1110,
        SPT_MODE_I2C_S10SP = 4'b1111
    } spt_mode_type;

    typedef enum logic [1:0]
    {
        SPT_IDLE = 2'b00,
        SPT_SHIFT = 2'b01
    } spt_state_type;

    // ======================================================================
    // AXI4-Lite slave carrier.
    typedef struct packed
    {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } spt_axi_req_type;

    typedef struct packed
    {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } spt_axi_rsp_type;

    // ======================================================================
    // Events from the two-wire bus sequencer, and settings back to it.
    typedef struct packed
    {
        logic startDet;
        logic stopDet;
        logic nackDet;
        logic addrMatch;
        logic rwBit;
        logic byteMoved;
        logic byteIsData;
        logic rxValid;
        logic [7:0] rxData;
        logic txDone;
        logic txBusy;
        logic addrUpdate;
        logic requestDone;
    } spt_i2c_ev_type;

    typedef struct packed
    {
        logic slewControlEn;
        logic smbusInputsEn;
        logic [7:0] ownAddress;
        logic [6:0] baudReload;
        logic [7:0] txShift;
        logic [4:0] requests;
        logic portIdle;
    } spt_i2c_ctl_type;

endpackage

// ==== src/spt_serial_port.sv ====
`timescale 1ns/1ps
`include "spt_params.svh"

module spt_serial_port
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire spt_pkg::spt_axi_req_type axiReq,
    output spt_pkg::spt_axi_rsp_type axiRsp,
    input wire logic serialClkIn,
    output logic serialClkOut,
    output logic serialClkOutEn,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutEn,
    input wire logic selectN,
    input wire logic timerTick,
    input wire logic sleepMode,
    output logic portIrqFlag,
    input wire logic irqFlagClear,
    input wire spt_pkg::spt_i2c_ev_type i2cEv,
    output spt_pkg::spt_i2c_ctl_type i2cCtl
);
    import spt_pkg::*;

    // ======================================================================
    // Helpers.
    function automatic logic [7:0] spt_half_len(input logic [3:0] m);
        logic [7:0] r;
        r = `SPT_HALF_DIV64;
        if (m == SPT_MODE_MDIV4)
            r = `SPT_HALF_DIV4;
        else if (m == SPT_MODE_MDIV16)
            r = `SPT_HALF_DIV16;
        return r;
    endfunction

    function automatic logic spt_known(input logic [7:0] a);
        return (a == `SPT_OFF_BUFFER) || (a == `SPT_OFF_CTRL1) || (a == `SPT_OFF_STATUS)
            || (a == `SPT_OFF_ADDR) || (a == `SPT_OFF_CTRL2);
    endfunction

    // ======================================================================
    // State.
    logic [7:0] ctrl1_q, ctrl1_d, ctrl2_q, addrReg_q, bufReg_q, shiftReg_q;
    logic [1:0] stTop_q;
    logic bufFull_q, irq_q, startSeen_q, stopSeen_q, rwFlag_q, daFlag_q, uaFlag_q;
    logic outBit_q, phase_q, phasePrev_q;
    logic [2:0] bitCount_q;
    logic [3:0] edgeCount_q;
    logic [7:0] divCnt_q;
    spt_state_type state_q;
    logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q, rdata_q;
    logic [3:0] wStrb_q;
    logic [1:0] bresp_q, rresp_q;

    // ======================================================================
    // Mode decode.
    wire portEnable = ctrl1_q[`SPT_C1_EN];
    wire idleClockLevel = ctrl1_q[`SPT_C1_CKP];
    wire [3:0] portModeField = ctrl1_q[3:0];
    wire inputSamplePhase = stTop_q[1];
    wire edgeSelect = stTop_q[0];
    wire masterMode = portModeField[3:2] == 2'b00;
    wire slaveSelMode = portModeField == SPT_MODE_SSEL;
    wire slaveFreeMode = portModeField == SPT_MODE_SFREE;
    wire spiMode = portEnable && (masterMode || slaveSelMode || slaveFreeMode);
    wire i2cMaster = (portModeField == SPT_MODE_I2C_M) || (portModeField == SPT_MODE_I2C_FW);
    wire i2cSlave = (portModeField[3:1] == 3'b011) || (portModeField[3:1] == 3'b111);
    wire i2cSlave10 = i2cSlave && portModeField[0];
    wire i2cMode = portEnable && (i2cMaster || i2cSlave);

    // ======================================================================
    // Register bus.
    wire awFire = axiReq.awvalid && axiRsp.awready;
    wire wFire = axiReq.wvalid && axiRsp.wready;
    wire arFire = axiReq.arvalid && axiRsp.arready;
    wire wrDo = awHeld_q && wHeld_q && !bvalid_q;
    wire wrLane = wrDo && wStrb_q[0];
    wire wrBuf = wrLane && (awAddr_q == `SPT_OFF_BUFFER);
    wire wrCtrl1 = wrLane && (awAddr_q == `SPT_OFF_CTRL1);
    wire wrStat = wrLane && (awAddr_q == `SPT_OFF_STATUS);
    wire wrAddr = wrLane && (awAddr_q == `SPT_OFF_ADDR);
    wire wrCtrl2 = wrLane && (awAddr_q == `SPT_OFF_CTRL2);
    wire rdBuf = arFire && (axiReq.araddr == `SPT_OFF_BUFFER);

    assign axiRsp.awready = !awHeld_q;
    assign axiRsp.wready = !wHeld_q;
    assign axiRsp.bvalid = bvalid_q;
    assign axiRsp.bresp = bresp_q;
    assign axiRsp.arready = !rvalid_q;
    assign axiRsp.rvalid = rvalid_q;
    assign axiRsp.rdata = rdata_q;
    assign axiRsp.rresp = rresp_q;

    // ======================================================================
    // Serial clock phase and edges.
    wire spiReset = !portEnable || (slaveSelMode && selectN);
    wire slaveActive = spiMode && (slaveFreeMode || (slaveSelMode && !selectN));
    wire masterRun = spiMode && masterMode && (state_q == SPT_SHIFT) && !sleepMode;
    wire phaseNow = masterMode ? phase_q : (serialClkIn ^ idleClockLevel);
    wire leadEdge = phaseNow && !phasePrev_q;
    wire trailEdge = !phaseNow && phasePrev_q;
    wire shiftLive = slaveActive || (spiMode && masterMode && state_q == SPT_SHIFT);
    wire sampleGo = shiftLive && !spiReset && (edgeSelect ? leadEdge : trailEdge);
    wire shiftGo = shiftLive && !spiReset && (edgeSelect ? trailEdge : leadEdge);
    wire halfDone = (portModeField == SPT_MODE_MTIMER) ? timerTick
        : (divCnt_q == spt_half_len(portModeField) - 8'h01);
    wire advance = masterRun && halfDone;

    // ======================================================================
    // Buffer, collision and receive.
    wire spiBusy = (state_q == SPT_SHIFT) || (bitCount_q != 3'h0);
    wire collide = wrBuf && ((spiMode && spiBusy) || (i2cMode && i2cEv.txBusy));
    wire txLoad = wrBuf && !collide;
    wire spiByteDone = sampleGo && (bitCount_q == `SPT_LAST_BIT);
    wire [7:0] spiByte = {shiftReg_q[6:0], serialIn};
    wire rxStrobe = spiByteDone || (i2cMode && i2cEv.rxValid);
    wire [7:0] rxByte = spiMode ? spiByte : i2cEv.rxData;
    wire rxLoad = rxStrobe && !bufFull_q && !ctrl1_q[`SPT_C1_OVF];
    wire ovfSet = rxStrobe && bufFull_q;
    wire bfSet = rxLoad || (i2cMode && txLoad);
    wire bfClr = rdBuf || (i2cMode && i2cEv.txDone);
    wire rwView = i2cMaster ? i2cEv.txBusy : rwFlag_q;
    wire [7:0] statusView = {stTop_q, i2cSlave && daFlag_q, stopSeen_q, startSeen_q,
        rwView, uaFlag_q, bufFull_q};

    always_comb
    begin
        ctrl1_d = ctrl1_q;
        if (wrCtrl1)
            ctrl1_d = wData_q[7:0];
        ctrl1_d[`SPT_C1_WCOL] = ctrl1_d[`SPT_C1_WCOL] | collide;
        ctrl1_d[`SPT_C1_OVF] = ctrl1_d[`SPT_C1_OVF] | ovfSet;
    end

    // ======================================================================
    // Bus handshake flops.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bvalid_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            bresp_q <= `SPT_RESP_OKAY;
        end
        else if (clkEn)
        begin
            awHeld_q <= awFire || (awHeld_q && !wrDo);
            wHeld_q <= wFire || (wHeld_q && !wrDo);
            if (awFire)
                awAddr_q <= axiReq.awaddr;
            if (wFire)
                wData_q <= axiReq.wdata;
            if (wFire)
                wStrb_q <= axiReq.wstrb;
            bvalid_q <= wrDo || (bvalid_q && !axiReq.bready);
            if (wrDo)
                bresp_q <= spt_known(awAddr_q) ? `SPT_RESP_OKAY : `SPT_RESP_SLVERR;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `SPT_RESP_OKAY;
        end
        else if (clkEn)
        begin
            rvalid_q <= arFire || (rvalid_q && !axiReq.rready);
            if (arFire)
            begin
                rresp_q <= spt_known(axiReq.araddr) ? `SPT_RESP_OKAY : `SPT_RESP_SLVERR;
                if (axiReq.araddr == `SPT_OFF_BUFFER)
                    rdata_q <= {24'h00_0000, bufReg_q};
                else if (axiReq.araddr == `SPT_OFF_CTRL1)
                    rdata_q <= {24'h00_0000, ctrl1_q};
                else if (axiReq.araddr == `SPT_OFF_STATUS)
                    rdata_q <= {24'h00_0000, statusView};
                else if (axiReq.araddr == `SPT_OFF_ADDR)
                    rdata_q <= {24'h00_0000, addrReg_q};
                else if (axiReq.araddr == `SPT_OFF_CTRL2)
                    rdata_q <= {24'h00_0000, ctrl2_q};
                else
                    rdata_q <= 32'h0000_0000;
            end
        end
    end

    // ======================================================================
    // Software registers.  Hardware set wins over a software clear.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl1_q <= `SPT_CTRL1_RESET;
            ctrl2_q <= `SPT_CTRL2_RESET;
            addrReg_q <= `SPT_ADDR_RESET;
            stTop_q <= `SPT_STATUS_RESET;
        end
        else if (clkEn)
        begin
            ctrl1_q <= ctrl1_d;
            if (wrStat)
                stTop_q <= wData_q[7:6];
            if (wrAddr)
                addrReg_q <= wData_q[7:0];
            if (wrCtrl2)
                ctrl2_q <= wData_q[7:0];
            else if (i2cEv.requestDone)
                ctrl2_q <= {ctrl2_q[7:5], 5'h00};
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            bufReg_q <= 8'h00;
            bufFull_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (txLoad)
                bufReg_q <= wData_q[7:0];
            else if (rxLoad)
                bufReg_q <= rxByte;
            bufFull_q <= bfSet || (bufFull_q && !bfClr);
            irq_q <= rxStrobe || (irq_q && !irqFlagClear);
        end
    end

    // ======================================================================
    // Two-wire status flags.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            startSeen_q <= 1'b0;
            stopSeen_q <= 1'b0;
            rwFlag_q <= 1'b0;
            daFlag_q <= 1'b0;
            uaFlag_q <= 1'b0;
        end
        else if (clkEn)
        begin
            startSeen_q <= portEnable && (i2cEv.startDet || (startSeen_q && !i2cEv.stopDet));
            stopSeen_q <= portEnable && (i2cEv.stopDet || (stopSeen_q && !i2cEv.startDet));
            if (i2cEv.addrMatch)
                rwFlag_q <= i2cEv.rwBit;
            else if (i2cEv.startDet || i2cEv.stopDet || i2cEv.nackDet)
                rwFlag_q <= 1'b0;
            if (i2cEv.byteMoved)
                daFlag_q <= i2cEv.byteIsData;
            uaFlag_q <= (i2cSlave10 && i2cEv.addrUpdate) || (uaFlag_q && !wrAddr);
        end
    end

    // ======================================================================
    // Shift register and bit counter.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            shiftReg_q <= 8'h00;
            outBit_q <= 1'b0;
            bitCount_q <= 3'h0;
        end
        else if (clkEn)
        begin
            if (txLoad)
                shiftReg_q <= wData_q[7:0];
            else if (sampleGo)
                shiftReg_q <= spiByte;
            if (txLoad)
                outBit_q <= wData_q[7];
            else if (shiftGo)
                outBit_q <= shiftReg_q[7];
            if (spiReset)
                bitCount_q <= 3'h0;
            else if (sampleGo)
                bitCount_q <= bitCount_q + 3'h1;
        end
    end

    // ======================================================================
    // Master clock generator.  Sleep holds every count, so a transfer resumes
    // exactly where it stopped.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= SPT_IDLE;
            phase_q <= 1'b0;
            phasePrev_q <= 1'b0;
            edgeCount_q <= 4'h0;
            divCnt_q <= 8'h00;
        end
        else if (clkEn)
        begin
            phasePrev_q <= phaseNow;
            case (state_q)
                SPT_IDLE:
                begin
                    phase_q <= 1'b0;
                    edgeCount_q <= 4'h0;
                    divCnt_q <= 8'h00;
                    if (txLoad && spiMode && masterMode)
                        state_q <= SPT_SHIFT;
                end
                SPT_SHIFT:
                begin
                    if (spiReset || !masterMode)
                        state_q <= SPT_IDLE;
                    else if (advance)
                    begin
                        phase_q <= !phase_q;
                        divCnt_q <= 8'h00;
                        edgeCount_q <= edgeCount_q + 4'h1;
                        if (edgeCount_q == `SPT_LAST_EDGE)
                            state_q <= SPT_IDLE;
                    end
                    else if (masterRun)
                        divCnt_q <= divCnt_q + 8'h01;
                end
                default:
                    state_q <= SPT_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Pins and two-wire settings.
    assign serialClkOut = idleClockLevel ^ (phase_q && state_q == SPT_SHIFT);
    assign serialClkOutEn = spiMode && masterMode;
    assign serialOut = outBit_q;
    assign serialOutEn = slaveActive || (spiMode && masterMode);
    assign portIrqFlag = irq_q;
    assign i2cCtl.slewControlEn = i2cMode && !inputSamplePhase;
    assign i2cCtl.smbusInputsEn = i2cMode && edgeSelect;
    assign i2cCtl.ownAddress = addrReg_q;
    assign i2cCtl.baudReload = addrReg_q[6:0];
    assign i2cCtl.txShift = shiftReg_q;
    assign i2cCtl.requests = ctrl2_q[4:0];
    assign i2cCtl.portIdle = !(rwView || (|ctrl2_q[4:0]));

    // ======================================================================
    // Checks.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    out_float_a: assert property (slaveSelMode && selectN |-> !serialOutEn)
        else $error("Data output driven while select is high.");
    out_drive_a: assert property (portEnable && slaveSelMode && !selectN |-> serialOutEn)
        else $error("Data output not driven while select is low.");
    cnt_clear_a: assert property (clkEn && spiReset |=> bitCount_q == 3'h0)
        else $error("Bit counter not cleared by logic reset.");
    rx_load_a: assert property (clkEn && spiByteDone && !bufFull_q && !ctrl1_q[6]
        |=> bufReg_q == $past(spiByte) && bufFull_q && irq_q)
        else $error("Received byte not moved to buffer.");
    tx_load_a: assert property (clkEn && txLoad |=> shiftReg_q == $past(wData_q[7:0]))
        else $error("Buffer write did not load shift register.");
    stat_write_a: assert property (clkEn && wrStat && !bfSet && !bfClr
        |=> stTop_q == $past(wData_q[7:6]) && bufFull_q == $past(bufFull_q))
        else $error("Status write mishandled.");
    sleep_freeze_a: assert property (clkEn && sleepMode && masterMode && state_q == SPT_SHIFT
        && !spiReset |=> $stable(edgeCount_q) && $stable(phase_q))
        else $error("Master transfer moved during sleep.");
    idle_clock_a: assert property (state_q == SPT_IDLE |-> serialClkOut == idleClockLevel)
        else $error("Clock not at idle level.");
    flag_clear_a: assert property (clkEn && !portEnable |=> !startSeen_q && !stopSeen_q)
        else $error("Start or stop flag survived disable.");
    slave_irq_a: assert property (clkEn && sleepMode && slaveActive && spiByteDone
        |=> portIrqFlag)
        else $error("Slave byte in sleep did not raise the flag.");

endmodule // spt_serial_port

// ==== verification/spt_spi_far.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Far-side SPI master, mode 0,0: data set while the clock is low, sampled on
// the rise. The clock stands still at its idle level outside frames.
module spt_spi_far
(
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] txByte,
    input wire logic miso,
    output logic sclk,
    output logic mosi,
    output logic [7:0] rxByte
);
    initial
    begin
        sclk = 1'b0;
        mosi = 1'b0;
        rxByte = 8'h00;
    end
    always @(posedge go)
    begin
        for (int i = 7; i >= 0; i--)
        begin
            mosi <= txByte[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            rxByte <= {rxByte[6:0], miso};
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        // The line is no longer held after the frame, so it shows the inverse.
        mosi <= ~mosi;
    end
endmodule // spt_spi_far

// ==== verification/sync_serial_spi_i2c_port_bench.sv ====
`timescale 1ns/1ps
module sync_serial_spi_i2c_port_bench;
    import spt_pkg::*;
    logic clk = 1'b0, reset = 1'b1, selectN = 1'b1, sleepMode = 1'b0, go = 1'b0, clr = 1'b0;
    spt_axi_req_type req = '0;
    spt_axi_rsp_type rsp;
    spt_i2c_ev_type ev = '0;
    spt_i2c_ctl_type ctl;
    logic sco, scoEn, so, soEn, irq, sclk, mosi, scoQ = 1'b0, tick = 1'b0;
    logic [7:0] farTx = 8'h00, farRx;
    logic [31:0] rd;
    logic [1:0] rr, br;
    int errors = 0, checked = 0, n, t, t0, toggles = 0;
    localparam logic [7:0] rowA [5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    localparam logic [7:0] rowW [5] = '{8'h14, 8'hFF, 8'hA7, 8'h1F, 8'h55};
    localparam logic [7:0] rowE [5] = '{8'h14, 8'hC0, 8'hA7, 8'h1F, 8'h00};
    localparam logic [1:0] rowR [5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        scoQ <= sco;
        tick <= ~tick;
        if (sco !== scoQ) toggles <= toggles + 1;
    end
    // ======================================================================
    // Design and far side; in master modes the data output loops back.
    spt_serial_port spt_serial_port_i
    (
        .clk(clk), .reset(reset), .clkEn(1'b1), .axiReq(req), .axiRsp(rsp),
        .serialClkIn(sclk), .serialClkOut(sco), .serialClkOutEn(scoEn),
        .serialIn(scoEn ? so : mosi), .serialOut(so), .serialOutEn(soEn),
        .selectN(selectN), .timerTick(tick), .sleepMode(sleepMode),
        .portIrqFlag(irq), .irqFlagClear(clr), .i2cEv(ev), .i2cCtl(ctl)
    );
    spt_spi_far spt_spi_far_i
    (
        .clk(clk), .go(go), .txByte(farTx), .miso(soEn ? so : ~so), .sclk(sclk), .mosi(mosi),
        .rxByte(farRx)
    );
    // ======================================================================
    // Shared tasks.
    task automatic conclude;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic stall;
        errors++;
        conclude();
    endtask
    task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            br = rsp.bresp;
            n++;
        end
        while (rsp.bvalid !== 1'b1 && n < 99);
        req.bready <= 1'b0;
        if (n >= 99) stall();
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
            rd = rsp.rdata;
            rr = rsp.rresp;
            n++;
        end
        while (rsp.rvalid !== 1'b1 && n < 99);
        req.rready <= 1'b0;
        if (n >= 99) stall();
    endtask
    // A sticky flag: waiting on it is bounded, since a lost byte would hang.
    task automatic waitIrq;
        n = 0;
        while (irq !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) stall();
    endtask
    // ======================================================================
    // Main sequence.
    initial
    begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rdr(8'h04);
        cmp("ctrl1 reset", 8'h00, rd);
        for (int i = 0; i < 5; i++)
        begin
            wr(rowA[i], rowW[i]);
            rdr(rowA[i]);
            cmp("row data", rowE[i], rd);
            cmp("row resp", rowR[i], rr);
            cmp("row bresp", rowR[i], br);
        end
        wr(8'h04, 8'h26);
        cmp("slew", 1'b0, ctl.slewControlEn);
        cmp("smbus", 1'b1, ctl.smbusInputsEn);
        cmp("own", 8'hA7, ctl.ownAddress);
        cmp("baud", 7'h27, ctl.baudReload);
        cmp("idle", 1'b0, ctl.portIdle);
        cmp("requests", 8'h1F, ctl.requests);
        ev.startDet <= 1'b1;
        @(posedge clk);
        ev.startDet <= 1'b0;
        rdr(8'h08);
        cmp("start", 8'h08, rd & 8'h18);
        ev.stopDet <= 1'b1;
        @(posedge clk);
        ev.stopDet <= 1'b0;
        rdr(8'h08);
        cmp("stop", 8'h10, rd & 8'h18);
        wr(8'h04, 8'h27);
        ev.addrMatch <= 1'b1;
        ev.rwBit <= 1'b1;
        ev.byteMoved <= 1'b1;
        ev.byteIsData <= 1'b1;
        ev.addrUpdate <= 1'b1;
        @(posedge clk);
        ev <= '0;
        rdr(8'h08);
        cmp("i2c flags", 8'h26, rd & 8'h26);
        wr(8'h0C, 8'hA7);
        rdr(8'h08);
        cmp("ua clear", 8'h00, rd & 8'h02);
        wr(8'h04, 8'h28);
        ev.requestDone <= 1'b1;
        @(posedge clk);
        ev.requestDone <= 1'b0;
        @(posedge clk);
        cmp("idle", 1'b1, ctl.portIdle);
        ev.txBusy <= 1'b1;
        @(posedge clk);
        #1 cmp("busy", 1'b0, ctl.portIdle);
        ev.txBusy <= 1'b0;
        wr(8'h08, 8'h40);
        cmp("slew on", 1'b1, ctl.slewControlEn);
        wr(8'h04, 8'h06);
        rdr(8'h08);
        cmp("disable", 8'h00, rd & 8'h18);
        wr(8'h04, 8'h24);
        wr(8'h00, 8'hA5);
        cmp("shift", 8'hA5, ctl.txShift);
        sleepMode <= 1'b1;
        selectN <= 1'b0;
        @(posedge clk);
        #1 cmp("drive", 1'b1, soEn);
        farTx <= 8'h3C;
        go <= 1'b1;
        waitIrq();
        go <= 1'b0;
        cmp("far rx", 8'hA5, farRx);
        rdr(8'h08);
        cmp("full", 1'b1, rd[0]);
        rdr(8'h00);
        cmp("buffer", 8'h3C, rd);
        rdr(8'h08);
        cmp("empty", 1'b0, rd[0]);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        go <= 1'b1;
        repeat (30) @(posedge clk);
        selectN <= 1'b1;
        @(posedge clk);
        #1 cmp("release", 1'b0, soEn);
        go <= 1'b0;
        repeat (50) @(posedge clk);
        cmp("no byte", 1'b0, irq);
        selectN <= 1'b0;
        go <= 1'b1;
        waitIrq();
        go <= 1'b0;
        rdr(8'h00);
        cmp("resync", 8'h3C, rd);
        clr <= 1'b1;
        sleepMode <= 1'b0;
        @(posedge clk);
        clr <= 1'b0;
        wr(8'h04, 8'h20);
        t0 = toggles;
        wr(8'h00, 8'h81);
        repeat (9) @(posedge clk);
        sleepMode <= 1'b1;
        repeat (2) @(posedge clk);
        t = toggles;
        repeat (20) @(posedge clk);
        cmp("frozen", t, toggles);
        sleepMode <= 1'b0;
        waitIrq();
        repeat (8) @(posedge clk);
        cmp("edges", t0 + 16, toggles);
        rdr(8'h00);
        cmp("loop", 8'h81, rd);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        wr(8'h04, 8'h23);
        wr(8'h00, 8'h5A);
        waitIrq();
        rdr(8'h00);
        cmp("timer", 8'h5A, rd);
        wr(8'h00, 8'h42);
        repeat (5) @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        #1 cmp("abort", 1'b0, scoEn);
        @(posedge clk);
        reset <= 1'b0;
        rdr(8'h04);
        cmp("disabled", 8'h00, rd);
        conclude();
    end
endmodule // sync_serial_spi_i2c_port_bench
